// file: hdl/opts_pkg.sv
// constants shared by the optical pulse timing sequencer and its testbench
// assumes one 40 MHz reference clock; the crystal master clock is emulated by a divider
package opts_pkg;

    // clocking
    localparam int unsigned REF_CLK_HZ  = 40_000_000;
    localparam int unsigned XTAL_HZ     = 8_000_000;
    localparam int unsigned MASTER_DIV  = REF_CLK_HZ / XTAL_HZ;
    localparam int unsigned WORK_DIV    = 2;
    localparam int unsigned EDGE_STEP_NS = 250;
    localparam int unsigned EDGE_STEP_CYCLES = (EDGE_STEP_NS * (REF_CLK_HZ / 1_000_000)) / 1000;

    // widths
    localparam int unsigned CNT_W    = 16;
    localparam int unsigned ADC_W    = 22;
    localparam int unsigned IDX_W    = 6;
    localparam int unsigned NUM_UNITS = 10;
    localparam int unsigned CONV_PAIRS = 4;

    // reference register indices (start at index, stop at index + 1)
    localparam logic [IDX_W-1:0] IDX_RED_SAMPLE     = 6'h01;
    localparam logic [IDX_W-1:0] IDX_RED_EMITTER    = 6'h03;
    localparam logic [IDX_W-1:0] IDX_RED_AMB_SAMPLE = 6'h05;
    localparam logic [IDX_W-1:0] IDX_IR_SAMPLE      = 6'h07;
    localparam logic [IDX_W-1:0] IDX_IR_EMITTER     = 6'h09;
    localparam logic [IDX_W-1:0] IDX_IR_AMB_SAMPLE  = 6'h0b;
    localparam logic [IDX_W-1:0] IDX_RED_CONV       = 6'h0d;
    localparam logic [IDX_W-1:0] IDX_RED_AMB_CONV   = 6'h0f;
    localparam logic [IDX_W-1:0] IDX_IR_CONV        = 6'h11;
    localparam logic [IDX_W-1:0] IDX_IR_AMB_CONV    = 6'h13;
    localparam logic [IDX_W-1:0] IDX_CONV_RESET     = 6'h15;
    localparam logic [IDX_W-1:0] IDX_PERIOD         = 6'h1d;
    localparam logic [IDX_W-1:0] IDX_CANCEL         = 6'h1e;
    localparam logic [IDX_W-1:0] IDX_GAIN           = 6'h1f;
    localparam logic [IDX_W-1:0] IDX_FIRST          = 6'h01;

    // base index of each single-pair unit, in output order
    localparam logic [IDX_W-1:0] UNIT_BASE [NUM_UNITS] = '{
        IDX_RED_SAMPLE, IDX_RED_EMITTER, IDX_RED_AMB_SAMPLE, IDX_IR_SAMPLE,
        IDX_IR_EMITTER, IDX_IR_AMB_SAMPLE, IDX_RED_CONV, IDX_RED_AMB_CONV,
        IDX_IR_CONV, IDX_IR_AMB_CONV};

    // reset values
    localparam logic [CNT_W-1:0] REF_RESET    = 16'h0000;
    localparam logic [CNT_W-1:0] PERIOD_RESET = 16'h0000;

    // ambient cancellation and second-stage gain
    localparam int unsigned CANCEL_STEPS = 10;
    localparam logic [3:0]  CANCEL_MAX   = 4'h9;
    localparam logic [3:0]  CANCEL_RESET = 4'h0;

    typedef enum logic [2:0]
    {
        GAIN_0DB   = 3'h0,
        GAIN_3P5DB = 3'h1,
        GAIN_6DB   = 3'h2,
        GAIN_9P5DB = 3'h3,
        GAIN_12DB  = 3'h4
    } gain_t;

    // conversion slot along the period, gray coded
    typedef enum logic [1:0]
    {
        SLOT_RED     = 2'b00,
        SLOT_RED_AMB = 2'b01,
        SLOT_IR      = 2'b11,
        SLOT_IR_AMB  = 2'b10
    } slot_t;

endpackage

// file: hdl/edge_compare.sv
// one timer compare unit with one or more start/stop reference pairs
// assumes count_next is the counter value taking effect on the tick edge
`timescale 1ns/1ps
`default_nettype none

module edge_compare #(
    parameter int unsigned PAIRS = 1,
    parameter int unsigned CNT_W = 16
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    // time base
    input  wire logic                   tick,
    input  wire logic [CNT_W-1:0]       count_next,
    // references
    input  wire logic [PAIRS*CNT_W-1:0] start_ref,
    input  wire logic [PAIRS*CNT_W-1:0] stop_ref,
    // output level and per-pair start pulses
    output logic                        out_q,
    output logic [PAIRS-1:0]            start_pulse_q
);

    logic [PAIRS-1:0] start_hit;
    logic [PAIRS-1:0] stop_hit;
    logic             stop_pend_q;

    // compare the coming counter value against every pair
    always_comb
    begin
        for (int i = 0; i < PAIRS; i++)
        begin
            start_hit[i] = count_next == start_ref[i*CNT_W +: CNT_W];
            stop_hit[i]  = count_next == stop_ref[i*CNT_W +: CNT_W];
        end
    end

    // level stays high through the stop count, drops on the next tick
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            out_q       <= 1'b0;
            stop_pend_q <= 1'b0;
        end
        else if (tick)
        begin
            stop_pend_q <= |stop_hit;
            if (|start_hit)
                out_q <= 1'b1;
            else if (stop_pend_q)
                out_q <= 1'b0;
        end
    end

    // which pair started, one cycle wide
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            start_pulse_q <= '0;
        else
            start_pulse_q <= tick ? start_hit : '0;
    end

    property p_start_sets;
        @(posedge ref_clk) disable iff (!reset_n)
        tick && |start_hit |=> out_q;
    endproperty
    a_start_sets: assert property (p_start_sets) else $error("start match did not set output");

    property p_stop_clears;
        @(posedge ref_clk) disable iff (!reset_n)
        tick && stop_pend_q && !(|start_hit) |=> !out_q;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop did not clear output");

    // high for ten cycles, then low unless a start matched again on that tick
    sequence s_one_work_cycle;
        out_q [*8] ##1 out_q [*2] ##1 (!out_q || $past(|start_hit));
    endsequence

    property p_equal_pulse;
        @(posedge ref_clk) disable iff (!reset_n)
        tick && (start_hit[0] && stop_hit[0]) |=> s_one_work_cycle;
    endproperty
    a_equal_pulse: assert property (p_equal_pulse) else $error("equal refs pulse too short");

endmodule

`default_nettype wire

// file: hdl/optical_pulse_timing_sequencer.sv
// timing and sequencing core: clock divider, period counter, eleven compare
// outputs, conversion result capture and ambient subtraction
// assumes the serial host interface is decoded outside into index/data writes
`timescale 1ns/1ps
`default_nettype none

module optical_pulse_timing_sequencer #(
    parameter int unsigned CNT_W = opts_pkg::CNT_W,
    parameter int unsigned ADC_W = opts_pkg::ADC_W
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    // host configuration writes
    input  wire logic                   cfg_wr_en,
    input  wire logic [5:0]             cfg_wr_index,
    input  wire logic [CNT_W-1:0]       cfg_wr_data,
    // converter codes
    input  wire logic                   adc_code_valid,
    input  wire logic [ADC_W-1:0]       adc_code,
    // working clock out
    output logic                        work_clk_out,
    // emitter and receiver phases
    output logic                        red_emitter,
    output logic                        infrared_emitter,
    output logic                        red_sample_phase,
    output logic                        red_ambient_sample_phase,
    output logic                        infrared_sample_phase,
    output logic                        infrared_ambient_sample_phase,
    output logic                        red_convert_phase,
    output logic                        red_ambient_convert_phase,
    output logic                        infrared_convert_phase,
    output logic                        infrared_ambient_convert_phase,
    output logic                        convert_reset_phase,
    // analog settings
    output logic [3:0]                  cancel_step,
    output logic [2:0]                  gain_select,
    // results
    output logic [ADC_W-1:0]            red_result,
    output logic [ADC_W-1:0]            red_ambient_result,
    output logic [ADC_W-1:0]            infrared_result,
    output logic [ADC_W-1:0]            infrared_ambient_result,
    output logic [ADC_W:0]              red_net_result,
    output logic [ADC_W:0]              infrared_net_result,
    output logic                        result_ready
);

    localparam logic [2:0] MDIV_LAST = 3'(opts_pkg::MASTER_DIV - 1);

    logic [2:0]                  mdiv_q;
    logic                        master_tick;
    logic                        work_clk_q;
    logic                        tick;
    logic [CNT_W-1:0]            count_q;
    logic [CNT_W-1:0]            count_next;
    logic [CNT_W-1:0]            refs_q [1:28];
    logic [CNT_W-1:0]            period_q;
    logic [3:0]                  cancel_q;
    opts_pkg::gain_t             gain_q;
    logic [opts_pkg::NUM_UNITS-1:0] unit_out;
    logic                        reset_out;
    logic [opts_pkg::CONV_PAIRS-1:0] reset_start;
    logic [opts_pkg::CONV_PAIRS*CNT_W-1:0] conv_start_refs;
    logic [opts_pkg::CONV_PAIRS*CNT_W-1:0] conv_stop_refs;
    logic                        any_convert;
    logic                        got_code_q;
    logic [ADC_W-1:0]            code_q;
    opts_pkg::slot_t             slot_q;
    opts_pkg::slot_t             slot_d;
    logic [ADC_W-1:0]            red_q;
    logic [ADC_W-1:0]            red_amb_q;
    logic [ADC_W-1:0]            ir_q;
    logic [ADC_W-1:0]            ir_amb_q;
    logic [ADC_W:0]              red_net_q;
    logic [ADC_W:0]              ir_net_q;
    logic                        ready_q;

    // master clock emulated at crystal rate as a one-cycle strobe
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            mdiv_q <= 3'h0;
        else if (mdiv_q == MDIV_LAST)
            mdiv_q <= 3'h0;
        else
            mdiv_q <= mdiv_q + 3'h1;
    end

    assign master_tick = mdiv_q == MDIV_LAST;
    assign tick        = master_tick && !work_clk_q;   // working clock rising edge

    // divide by two; the flop itself is the outgoing clock pin
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            work_clk_q <= 1'b0;
        else if (master_tick)
            work_clk_q <= !work_clk_q;
    end

    assign work_clk_out = work_clk_q;

    // shared time base, one step per working cycle (0.25 us)
    assign count_next = (count_q == period_q) ? '0 : count_q + 16'h0001;

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            count_q <= '0;
        else if (tick)
            count_q <= count_next;
    end

    // host-written references; no limits placed on their values
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            for (int i = 1; i <= 28; i++)
                refs_q[i] <= opts_pkg::REF_RESET;
            period_q <= opts_pkg::PERIOD_RESET;
        end
        else if (cfg_wr_en)
        begin
            if (cfg_wr_index >= opts_pkg::IDX_FIRST && cfg_wr_index < opts_pkg::IDX_PERIOD)
                refs_q[cfg_wr_index[4:0]] <= cfg_wr_data;
            else if (cfg_wr_index == opts_pkg::IDX_PERIOD)
                period_q <= cfg_wr_data;
        end
    end

    // ambient cancellation step and gain; out-of-range writes are ignored
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            cancel_q <= opts_pkg::CANCEL_RESET;
            gain_q   <= opts_pkg::GAIN_0DB;
        end
        else if (cfg_wr_en)
        begin
            if (cfg_wr_index == opts_pkg::IDX_CANCEL && cfg_wr_data <= 16'(opts_pkg::CANCEL_MAX))
                cancel_q <= cfg_wr_data[3:0];
            if (cfg_wr_index == opts_pkg::IDX_GAIN
                && cfg_wr_data <= 16'(opts_pkg::GAIN_12DB))
                gain_q <= opts_pkg::gain_t'(cfg_wr_data[2:0]);
        end
    end

    assign cancel_step = cancel_q;
    assign gain_select = gain_q;

    // ten single-pair compare units
    generate
        for (genvar u = 0; u < opts_pkg::NUM_UNITS; u++)
        begin : g_unit
            localparam int unsigned B = int'(opts_pkg::UNIT_BASE[u]);
            edge_compare #(
                .PAIRS (1),
                .CNT_W (CNT_W)
            ) u_cmp (
                .ref_clk       (ref_clk),
                .reset_n       (reset_n),
                .tick          (tick),
                .count_next    (count_next),
                .start_ref     (refs_q[B]),
                .stop_ref      (refs_q[B+1]),
                .out_q         (unit_out[u]),
                .start_pulse_q ()
            );
        end
    endgenerate

    // the eleventh unit: four converter reset pulses per period
    always_comb
    begin
        for (int p = 0; p < opts_pkg::CONV_PAIRS; p++)
        begin
            conv_start_refs[p*CNT_W +: CNT_W] = refs_q[int'(opts_pkg::IDX_CONV_RESET) + 2*p];
            conv_stop_refs[p*CNT_W +: CNT_W]  = refs_q[int'(opts_pkg::IDX_CONV_RESET) + 2*p + 1];
        end
    end

    edge_compare #(
        .PAIRS (opts_pkg::CONV_PAIRS),
        .CNT_W (CNT_W)
    ) u_conv_reset (
        .ref_clk       (ref_clk),
        .reset_n       (reset_n),
        .tick          (tick),
        .count_next    (count_next),
        .start_ref     (conv_start_refs),
        .stop_ref      (conv_stop_refs),
        .out_q         (reset_out),
        .start_pulse_q (reset_start)
    );

    assign red_sample_phase               = unit_out[0];
    assign red_emitter                    = unit_out[1];
    assign red_ambient_sample_phase       = unit_out[2];
    assign infrared_sample_phase          = unit_out[3];
    assign infrared_emitter               = unit_out[4];
    assign infrared_ambient_sample_phase  = unit_out[5];
    assign red_convert_phase              = unit_out[6];
    assign red_ambient_convert_phase      = unit_out[7];
    assign infrared_convert_phase         = unit_out[8];
    assign infrared_ambient_convert_phase = unit_out[9];
    assign convert_reset_phase            = reset_out;

    assign any_convert = |unit_out[9:6];

    // keep the first code that the converter yields in each conversion;
    // a code in the same cycle as a reset start wins over the clear
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            got_code_q <= 1'b0;
            code_q     <= '0;
        end
        else if (adc_code_valid && any_convert && (!got_code_q || |reset_start))
        begin
            got_code_q <= 1'b1;
            code_q     <= adc_code;
        end
        else if (|reset_start)
            got_code_q <= 1'b0;
    end

    // slot follows which reset pulse opened the conversion; coinciding
    // pulses (all refs equal after reset) resolve to the lowest pair
    always_comb
    begin
        if (reset_start[0])
            slot_d = opts_pkg::SLOT_RED;
        else if (reset_start[1])
            slot_d = opts_pkg::SLOT_RED_AMB;
        else if (reset_start[2])
            slot_d = opts_pkg::SLOT_IR;
        else if (reset_start[3])
            slot_d = opts_pkg::SLOT_IR_AMB;
        else
            slot_d = slot_q;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            slot_q <= opts_pkg::SLOT_IR_AMB;
        else
            slot_q <= slot_d;
    end

    // each reset pulse stores the code of the slot that just ended
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            red_q     <= '0;
            red_amb_q <= '0;
            ir_q      <= '0;
            ir_amb_q  <= '0;
            red_net_q <= '0;
            ir_net_q  <= '0;
            ready_q   <= 1'b0;
        end
        else
        begin
            ready_q <= 1'b0;
            if (|reset_start)
            begin
                case (slot_q)
                    opts_pkg::SLOT_RED:     red_q     <= code_q;
                    opts_pkg::SLOT_RED_AMB: red_amb_q <= code_q;
                    opts_pkg::SLOT_IR:      ir_q      <= code_q;
                    opts_pkg::SLOT_IR_AMB:
                    begin
                        ir_amb_q  <= code_q;
                        red_net_q <= {red_q[ADC_W-1], red_q}
                                   - {red_amb_q[ADC_W-1], red_amb_q};
                        ir_net_q  <= {ir_q[ADC_W-1], ir_q}
                                   - {code_q[ADC_W-1], code_q};
                        ready_q   <= 1'b1;
                    end
                    default: ready_q <= 1'b0;
                endcase
            end
        end
    end

    assign red_result              = red_q;
    assign red_ambient_result      = red_amb_q;
    assign infrared_result         = ir_q;
    assign infrared_ambient_result = ir_amb_q;
    assign red_net_result          = red_net_q;
    assign infrared_net_result     = ir_net_q;
    assign result_ready            = ready_q;

    // ---- checks ----
    sequence s_tick_gap;
        !tick [*8] ##1 !tick;
    endsequence

    property p_work_period;
        @(posedge ref_clk) disable iff (!reset_n)
        tick |=> s_tick_gap ##1 tick;
    endproperty
    a_work_period: assert property (p_work_period) else $error("working tick not every ten cycles");

    property p_clk_out_half;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(work_clk_out) |-> work_clk_out [*5] ##1 !work_clk_out;
    endproperty
    a_clk_out_half: assert property (p_clk_out_half) else $error("clock out high time wrong");

    property p_count_step;
        @(posedge ref_clk) disable iff (!reset_n)
        tick && count_q != period_q |=> count_q == $past(count_q) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step by one");

    property p_wrap;
        @(posedge ref_clk) disable iff (!reset_n)
        tick && count_q == period_q |=> count_q == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap at period");

    property p_net_red;
        @(posedge ref_clk) disable iff (!reset_n)
        result_ready |-> red_net_result
            == ({red_result[ADC_W-1], red_result} - {red_ambient_result[ADC_W-1], red_ambient_result});
    endproperty
    a_net_red: assert property (p_net_red) else $error("red corrected result wrong");

    property p_net_ir;
        @(posedge ref_clk) disable iff (!reset_n)
        result_ready |-> infrared_net_result == ({infrared_result[ADC_W-1], infrared_result}
            - {infrared_ambient_result[ADC_W-1], infrared_ambient_result});
    endproperty
    a_net_ir: assert property (p_net_ir) else $error("infrared corrected result wrong");

    property p_cancel_range;
        @(posedge ref_clk) disable iff (!reset_n)
        cfg_wr_en && cfg_wr_index == opts_pkg::IDX_CANCEL && cfg_wr_data > 16'h0009
            |=> $stable(cancel_step) && cancel_step <= 4'h9;
    endproperty
    a_cancel_range: assert property (p_cancel_range) else $error("cancel step left its range");

    property p_gain_range;
        @(posedge ref_clk) disable iff (!reset_n)
        gain_select <= 3'h4;
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain select out of range");

    property p_ready_slot;
        @(posedge ref_clk) disable iff (!reset_n)
        result_ready |-> $past(reset_start[0]) && slot_q == opts_pkg::SLOT_RED;
    endproperty
    a_ready_slot: assert property (p_ready_slot) else $error("results published off the period start");

endmodule

`default_nettype wire

// file: sim/converter_model.sv
// converter stand-in: one code per conversion, then a stray second code
// assumes the four convert phase outputs are registered on ref_clk
`timescale 1ns/1ps
`default_nettype none

module converter_model (
    // clock and convert phases: red, red ambient, infrared, infrared ambient
    input  wire logic        ref_clk,
    input  wire logic [3:0]  phase,
    // converter codes
    output logic             adc_code_valid,
    output logic [21:0]      adc_code
);
    localparam logic [21:0] CODES [4] = '{22'h000100, 22'h000030, 22'h000200, 22'h000250};

    // answers each phase at once, then a junk code the design must ignore
    initial
    begin
        adc_code_valid = 1'b0;
        adc_code = 22'h155555;
        forever
        begin
            @(posedge ref_clk);
            #1;
            if (phase !== 4'h0)
            begin
                for (int k = 0; k < 4; k++)
                    if (phase[k]) adc_code = CODES[k];
                adc_code_valid = 1'b1;    // one code per conversion
                @(posedge ref_clk);
                #1;
                adc_code_valid = 1'b0;
                adc_code = ~adc_code;
                @(posedge ref_clk);
                #1;
                adc_code_valid = 1'b1;    // stray code in the same conversion
                @(posedge ref_clk);
                #1;
                adc_code_valid = 1'b0;
                adc_code = 22'h2aaaaa;
                wait (phase === 4'h0);
            end
        end
    end
endmodule

`default_nettype wire

// file: sim/optical_pulse_timing_sequencer_test.sv
// self-checking bench for the optical pulse timing sequencer
// assumes the converter stand-in answers on the convert phase outputs
`timescale 1ns/1ps
`default_nettype none

module optical_pulse_timing_sequencer_test;
    logic        ref_clk, reset_n, cfg_wr_en, adc_code_valid;
    logic [5:0]  cfg_wr_index;
    logic [15:0] cfg_wr_data;
    logic [21:0] adc_code;
    logic        work_clk_out, red_emitter, infrared_emitter, red_sample_phase;
    logic        red_ambient_sample_phase, infrared_sample_phase, infrared_ambient_sample_phase;
    logic        red_convert_phase, red_ambient_convert_phase, infrared_convert_phase;
    logic        infrared_ambient_convert_phase, convert_reset_phase, result_ready;
    logic [3:0]  cancel_step;
    logic [2:0]  gain_select;
    logic [21:0] red_result, red_ambient_result, infrared_result, infrared_ambient_result;
    logic [22:0] red_net_result, infrared_net_result;
    int          failures, checks, hi, rises, n;

    optical_pulse_timing_sequencer i_optical_pulse_timing_sequencer (
        .ref_clk, .reset_n, .cfg_wr_en, .cfg_wr_index, .cfg_wr_data, .adc_code_valid,
        .adc_code, .work_clk_out, .red_emitter, .infrared_emitter, .red_sample_phase,
        .red_ambient_sample_phase, .infrared_sample_phase, .infrared_ambient_sample_phase,
        .red_convert_phase, .red_ambient_convert_phase, .infrared_convert_phase,
        .infrared_ambient_convert_phase, .convert_reset_phase, .cancel_step, .gain_select,
        .red_result, .red_ambient_result, .infrared_result, .infrared_ambient_result,
        .red_net_result, .infrared_net_result, .result_ready);

    converter_model i_converter_model (
        .ref_clk,
        .phase({infrared_ambient_convert_phase, infrared_convert_phase,
                red_ambient_convert_phase, red_convert_phase}),
        .adc_code_valid, .adc_code);

    // compare, count and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one host write per cycle; back-to-back calls keep the strobe up
    task automatic wr(input logic [5:0] idx, input logic [15:0] data);
        @(posedge ref_clk);
        #1;
        cfg_wr_en = 1'b1;
        cfg_wr_index = idx;
        cfg_wr_data = data;
    endtask

    task automatic idle(input int cycles);
        @(posedge ref_clk);
        #1;
        cfg_wr_en = 1'b0;
        repeat (cycles) @(posedge ref_clk);
        #1;
    endtask

    // high cycles and rising edges of a level over a window
    task automatic count_high(ref logic sig, input int cycles);
        logic prev;
        prev = sig;
        hi = 0;
        rises = 0;
        repeat (cycles)
        begin
            @(posedge ref_clk);
            #1;
            if (sig === 1'b1) hi++;
            if (sig === 1'b1 && prev !== 1'b1) rises++;
            prev = sig;
        end
    endtask

    // wait, up to a limit, for a level to rise
    task automatic wait_rise(ref logic sig, input int limit);
        logic prev;
        prev = sig;
        n = 0;
        while (!(sig === 1'b1 && prev !== 1'b1) && n < limit)
        begin
            prev = sig;
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask

    task automatic test_clock;
        count_high(work_clk_out, 100);
        check(hi, 50);
        check(rises, 10);
    endtask

    // every cancel step and gain code, then out-of-range writes left unapplied
    task automatic test_settings;
        for (int v = 0; v < 10; v++)
        begin
            wr(opts_pkg::IDX_CANCEL, 16'(v));
            idle(0);
            check(cancel_step, v);
        end
        for (int v = 0; v < 5; v++)
        begin
            wr(opts_pkg::IDX_GAIN, 16'(v));
            idle(0);
            check(gain_select, v);
        end
        wr(opts_pkg::IDX_CANCEL, 16'h000a);
        wr(opts_pkg::IDX_GAIN, 16'h0005);
        idle(0);
        check(cancel_step, 4'h9);
        check(gain_select, 3'h4);
    endtask

    // period of 4 counts: span 1..2, single-count pulse, then a moved start
    task automatic test_timer;
        wr(opts_pkg::IDX_RED_EMITTER, 16'h0001);
        wr(opts_pkg::IDX_RED_EMITTER + 6'h01, 16'h0002);
        wr(opts_pkg::IDX_IR_EMITTER, 16'h0002);
        wr(opts_pkg::IDX_IR_EMITTER + 6'h01, 16'h0002);
        wr(opts_pkg::IDX_PERIOD, 16'h0003);    // references loaded before use
        idle(80);
        count_high(red_emitter, 160);
        check(hi, 80);
        check(rises, 4);
        count_high(infrared_emitter, 160);
        check(hi, 40);
        wr(opts_pkg::IDX_RED_EMITTER, 16'h0000);
        idle(80);
        count_high(red_emitter, 160);
        check(hi, 120);
    endtask

    // converter resets at quarters, conversions one count later, six results
    task automatic test_convert;
        for (int k = 0; k < 4; k++)
        begin
            wr(opts_pkg::IDX_CONV_RESET + 6'(2*k), 16'(2*k));
            wr(opts_pkg::IDX_CONV_RESET + 6'(2*k+1), 16'(2*k));
            wr(opts_pkg::UNIT_BASE[6+k], 16'(2*k+1));         // after sampling
            wr(opts_pkg::UNIT_BASE[6+k] + 6'h01, 16'(2*k+1));
        end
        wr(opts_pkg::IDX_PERIOD, 16'h0007);
        idle(80);
        count_high(convert_reset_phase, 160);
        check(rises, 8);
        check(hi, 80);
        n = 0;
        while (result_ready !== 1'b1 && n < 200)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(result_ready, 1'b1);
        check(red_result, 22'h000100);
        check(red_ambient_result, 22'h000030);
        check(infrared_result, 22'h000200);
        check(infrared_ambient_result, 22'h000250);
        check(red_net_result, 23'h0000d0);
        check(infrared_net_result, 23'h7fffb0);
        @(posedge ref_clk);
        #1;
        check(result_ready, 1'b0);
        wr(opts_pkg::IDX_CANCEL, 16'(red_ambient_result[7:4]));   // host closes loop
        idle(0);
        check(cancel_step, 4'h3);
    endtask

    // 200-count (50 us) sampling phases in an 800-count period, red inside its emitter
    task automatic test_sample;
        wr(opts_pkg::IDX_RED_EMITTER, 16'h0005);
        wr(opts_pkg::IDX_RED_EMITTER + 6'h01, 16'h00fa);      // settling lead
        for (int k = 0; k < 4; k++)
        begin
            wr(opts_pkg::UNIT_BASE[k + (k+1)/2], 16'h000a);
            wr(opts_pkg::UNIT_BASE[k + (k+1)/2] + 6'h01, 16'h00d1);
        end
        wr(opts_pkg::IDX_PERIOD, 16'h031f);                   // 800-count period
        idle(0);
        wait_rise(red_sample_phase, 9000);
        check(red_sample_phase, 1'b1);
        check(red_emitter, 1'b1);
        count_high(red_sample_phase, 8000);
        check(hi, 2000);
        check(rises, 1);
        count_high(red_ambient_sample_phase, 8000);
        check(hi, 2000);
        count_high(infrared_sample_phase, 8000);
        check(hi, 2000);
        count_high(infrared_ambient_sample_phase, 8000);
        check(hi, 2000);
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // 25 ns clock
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // watchdog well beyond the roughly 33000 cycles of the tests
    initial
    begin
        #2000000;
        failures++;
        complete_run;
    end

    // reset for 8 cycles, then the scenarios
    initial
    begin
        failures = 0;
        checks = 0;
        reset_n = 1'b0;
        cfg_wr_en = 1'b0;
        cfg_wr_index = 6'h00;
        cfg_wr_data = 16'h0000;
        repeat (8) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        check({cancel_step, gain_select, result_ready, red_net_result}, 32'h0);
        test_clock;
        test_settings;
        test_timer;
        test_convert;
        test_sample;
        complete_run;
    end
endmodule

`default_nettype wire
